// ### bsp_pkg.sv
package bsp_pkg;
  localparam int unsigned WORD_BITS          = 8;
  localparam logic [2:0]  BIT_LAST           = 3'h7;
  localparam logic [2:0]  BIT_FIRST          = 3'h0;
  localparam logic [1:0]  CLKSTOP_NO_DELAY   = 2'h2;
  localparam logic [1:0]  CLKSTOP_HALF_DELAY = 2'h3;
  localparam logic        DIV_SRC_CPU        = 1'h1;
  localparam logic        DIV_SRC_EXT        = 1'h0;
  localparam logic [7:0]  SLAVE_DIV_VALUE    = 8'h01;
  localparam logic        DIR_OUT            = 1'h1;
  localparam logic        DIR_IN             = 1'h0;
  localparam logic        FRAME_POL_INV      = 1'h1;
  localparam logic [8:0]  PHASE_MIN          = 9'h001;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LEAD = 3'b001,
    ST_HIGH = 3'b010,
    ST_LOW  = 3'b011,
    ST_TAIL = 3'b100,
    ST_HOLD = 3'b101
  } bsp_state_t;

  typedef struct packed {
    logic       master;
    logic [1:0] clock_stop_select;
    logic       transmit_clock_polarity;
    logic       divider_source_select;
    logic [7:0] divider_value;
  } bsp_cfg_t;
endpackage

// ### bsp_spi_clkstop.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1: slave needs cpu divider source, value one
// RULE2: divider input is cpu or external clock
// RULE3: clock period is divide value plus one; a zero divide value gives a period of two
// RULE4: high phase length from divide value parity
// RULE5: low phase length from divide value parity
// RULE6: master drives tx clock and frame pins
// RULE7: frame polarity set, master enable active low
// RULE8: slave inverts active-low enable inputs
// RULE9: enable low before first rising edge
// RULE10: mode 10b change on rise, sample fall
// RULE11: mode 11b change on fall, sample rise
// RULE12: enable lead and hold per mode
// RULE13: master floats data after last bit
// RULE14: slave drives after enable fall, releases after
// RULE15: external master supplies clock, holds enable
module bsp_spi_clkstop (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // configuration
  input  wire bsp_pkg::bsp_cfg_t i_cfg,
  input  wire logic              i_ext_div_clk,
  // word interface
  input  wire logic [7:0]        i_tx_data,
  input  wire logic              i_tx_valid,
  output logic                   o_tx_ready,
  output logic [7:0]             o_rx_data,
  output logic                   o_rx_valid,
  // status
  output logic                   o_busy,
  output logic                   o_cfg_error,
  output logic                   o_tx_clock_direction,
  output logic                   o_tx_frame_direction,
  output logic                   o_rx_clock_direction,
  output logic                   o_rx_frame_direction,
  output logic                   o_tx_frame_polarity,
  output logic                   o_rx_frame_polarity,
  // serial pins
  input  wire logic              i_serial_clock_pin,
  output logic                   o_serial_clock_pin,
  output logic                   o_serial_clock_pin_oe,
  input  wire logic              i_tx_frame_pin,
  output logic                   o_tx_frame_pin,
  output logic                   o_tx_frame_pin_oe,
  input  wire logic              i_rx_frame_pin,
  input  wire logic              i_serial_in_pin,
  output logic                   o_serial_out_pin,
  output logic                   o_serial_out_pin_oe
);
  localparam logic [8:0] PHASE_MIN   = bsp_pkg::PHASE_MIN;
  localparam logic [2:0] BIT_FIRST_C = bsp_pkg::BIT_FIRST;
  bsp_pkg::bsp_state_t state_reg, state_next;
  logic [8:0] cnt_reg, cnt_next, h_len, l_len;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] tx_sh_reg, tx_sh_next, rx_sh_reg, rx_sh_next, rx_data_next;
  logic       clk_int_reg, clk_int_next, sel_n_reg, sel_n_next;
  logic       dout_reg, dout_next, doe_reg, doe_next;
  logic       rx_valid_next, tx_ready_next, busy_next, err_next;
  logic       ext_prev_reg, sclk_prev_reg, txact_prev_reg, first_reg, first_next;
  logic       tick, expire, late, active, sample;
  logic       s_clk, s_rise, s_fall, tx_act, rx_act, load;

  always_comb begin
    // rounding: odd or zero splits evenly, even gives high the extra period
    if (i_cfg.divider_value[0] == 1'b0 && i_cfg.divider_value != 8'h00) begin
      // RULE4: even high length
      h_len = {2'h0, i_cfg.divider_value[7:1]} + PHASE_MIN;
      // RULE5: even low length
      l_len = {2'h0, i_cfg.divider_value[7:1]};
    end else begin
      h_len = ({1'b0, i_cfg.divider_value} + PHASE_MIN) >> 1;
      l_len = h_len;
    end
    // a zero divide value cannot be split in whole cycles, so stretch it
    if (h_len < PHASE_MIN) h_len = PHASE_MIN;
    if (l_len < PHASE_MIN) l_len = PHASE_MIN;
  end

  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    bit_next      = bit_reg;
    tx_sh_next    = tx_sh_reg;
    rx_sh_next    = rx_sh_reg;
    rx_data_next  = o_rx_data;
    rx_valid_next = 1'b0;
    clk_int_next  = clk_int_reg;
    sel_n_next    = sel_n_reg;
    dout_next     = dout_reg;
    doe_next      = doe_reg;
    first_next    = first_reg;
    sample        = 1'b0;
    load          = 1'b0;
    // RULE2: divider input select
    tick   = (i_cfg.divider_source_select == bsp_pkg::DIV_SRC_CPU) ? 1'b1
           : (i_ext_div_clk & ~ext_prev_reg);
    expire = tick && (cnt_reg == PHASE_MIN);
    if (tick && cnt_reg > PHASE_MIN) cnt_next = cnt_reg - PHASE_MIN;
    late   = (i_cfg.clock_stop_select == bsp_pkg::CLKSTOP_NO_DELAY);
    active = i_cfg.clock_stop_select[1];
    s_clk  = i_serial_clock_pin ^ i_cfg.transmit_clock_polarity;
    s_rise = s_clk & ~sclk_prev_reg;
    s_fall = ~s_clk & sclk_prev_reg;
    // RULE8: active-low enables inverted
    tx_act = ~i_tx_frame_pin;
    rx_act = ~i_rx_frame_pin;
    if (i_cfg.master) begin
      unique case (state_reg)
        bsp_pkg::ST_IDLE: begin
          if (active && i_tx_valid) begin
            load       = 1'b1;
            bit_next   = BIT_FIRST_C;
            // RULE9: enable asserted ahead of clock
            sel_n_next = 1'b0;
            // RULE12: lead is low phase or full period
            cnt_next   = late ? l_len : (l_len + h_len);
            state_next = bsp_pkg::ST_LEAD;
            tx_sh_next = i_tx_data;
            if (!late) begin
              // RULE11: first bit out before first rise
              dout_next  = i_tx_data[7];
              doe_next   = 1'b1;
              tx_sh_next = {i_tx_data[6:0], 1'b0};
            end
          end
        end
        bsp_pkg::ST_LEAD, bsp_pkg::ST_LOW: begin
          if (expire) begin
            clk_int_next = 1'b1;
            // RULE3: period is high plus low
            cnt_next     = h_len;
            state_next   = bsp_pkg::ST_HIGH;
            if (late) begin
              // RULE10: change after rising edge
              dout_next  = tx_sh_reg[7];
              doe_next   = 1'b1;
              tx_sh_next = {tx_sh_reg[6:0], 1'b0};
            end else begin
              // RULE11: sample on rising edge
              sample = 1'b1;
            end
          end
        end
        bsp_pkg::ST_HIGH: begin
          if (expire) begin
            clk_int_next = 1'b0;
            bit_next     = bit_reg + 3'h1;
            cnt_next     = l_len;
            // RULE10: sample on falling edge
            sample       = late;
            if (bit_reg == bsp_pkg::BIT_LAST) begin
              state_next = bsp_pkg::ST_TAIL;
              // RULE13: float at last fall in 11b
              if (!late) doe_next = 1'b0;
            end else begin
              state_next = bsp_pkg::ST_LOW;
              if (!late) begin
                // RULE11: change after falling edge
                dout_next  = tx_sh_reg[7];
                tx_sh_next = {tx_sh_reg[6:0], 1'b0};
              end
            end
          end
        end
        bsp_pkg::ST_TAIL: begin
          if (expire) begin
            // RULE13: float one low phase after in 10b
            doe_next = 1'b0;
            if (late) begin
              // RULE12: 10b holds a full period
              cnt_next   = h_len;
              state_next = bsp_pkg::ST_HOLD;
            end else begin
              sel_n_next = 1'b1;
              state_next = bsp_pkg::ST_IDLE;
            end
          end
        end
        bsp_pkg::ST_HOLD: begin
          if (expire) begin
            sel_n_next = 1'b1;
            state_next = bsp_pkg::ST_IDLE;
          end
        end
        default: state_next = bsp_pkg::ST_IDLE;
      endcase
    end else begin
      state_next   = bsp_pkg::ST_IDLE;
      sel_n_next   = 1'b1;
      clk_int_next = 1'b0;
      load         = i_tx_valid && o_tx_ready;
      if (load) tx_sh_next = i_tx_data;
      if (active && tx_act && !txact_prev_reg) begin
        // RULE14: first bit after enable falls
        dout_next  = tx_sh_reg[7];
        doe_next   = 1'b1;
        tx_sh_next = {tx_sh_reg[6:0], 1'b0};
        first_next = late;
        bit_next   = BIT_FIRST_C;
      end else if (!tx_act) begin
        // RULE14: release after enable rises
        doe_next = 1'b0;
      end else if (doe_reg && (late ? s_rise : s_fall)) begin
        // 10b keeps the first bit across the first rise
        first_next = 1'b0;
        if (!first_reg) begin
          dout_next  = tx_sh_reg[7];
          tx_sh_next = {tx_sh_reg[6:0], 1'b0};
        end
      end
      // RULE15: relies on master clock within enable
      if (active && rx_act && (late ? s_fall : s_rise)) begin
        sample   = 1'b1;
        bit_next = bit_reg + 3'h1;
      end
    end
    if (sample) begin
      rx_sh_next = {rx_sh_reg[6:0], i_serial_in_pin};
      if (bit_reg == bsp_pkg::BIT_LAST) begin
        rx_data_next  = rx_sh_next;
        rx_valid_next = 1'b1;
      end
    end
    tx_ready_next = i_cfg.master ? (active && state_next == bsp_pkg::ST_IDLE && !load)
                                 : (!tx_act && !load);
    busy_next     = i_cfg.master ? (state_next != bsp_pkg::ST_IDLE) : tx_act;
    // RULE1: slave divider setting checked
    err_next      = !i_cfg.master
                 && (i_cfg.divider_source_select != bsp_pkg::DIV_SRC_CPU
                  || i_cfg.divider_value != bsp_pkg::SLAVE_DIV_VALUE);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg             <= bsp_pkg::ST_IDLE;
      cnt_reg               <= PHASE_MIN;
      bit_reg               <= BIT_FIRST_C;
      tx_sh_reg             <= 8'h00;
      rx_sh_reg             <= 8'h00;
      o_rx_data             <= 8'h00;
      o_rx_valid            <= 1'b0;
      o_tx_ready            <= 1'b0;
      o_busy                <= 1'b0;
      o_cfg_error           <= 1'b0;
      clk_int_reg           <= 1'b0;
      sel_n_reg             <= 1'b1;
      dout_reg              <= 1'b0;
      doe_reg               <= 1'b0;
      first_reg             <= 1'b0;
      ext_prev_reg          <= 1'b0;
      sclk_prev_reg         <= 1'b0;
      txact_prev_reg        <= 1'b0;
      o_serial_clock_pin    <= 1'b0;
      o_serial_clock_pin_oe <= 1'b0;
      o_tx_frame_pin        <= 1'b1;
      o_tx_frame_pin_oe     <= 1'b0;
      o_serial_out_pin      <= 1'b0;
      o_serial_out_pin_oe   <= 1'b0;
      o_tx_clock_direction  <= bsp_pkg::DIR_IN;
      o_tx_frame_direction  <= bsp_pkg::DIR_IN;
      o_rx_clock_direction  <= bsp_pkg::DIR_IN;
      o_rx_frame_direction  <= bsp_pkg::DIR_IN;
      o_tx_frame_polarity   <= bsp_pkg::FRAME_POL_INV;
      o_rx_frame_polarity   <= bsp_pkg::FRAME_POL_INV;
    end else begin
      state_reg             <= state_next;
      cnt_reg               <= cnt_next;
      bit_reg               <= bit_next;
      tx_sh_reg             <= tx_sh_next;
      rx_sh_reg             <= rx_sh_next;
      o_rx_data             <= rx_data_next;
      o_rx_valid            <= rx_valid_next;
      o_tx_ready            <= tx_ready_next;
      o_busy                <= busy_next;
      o_cfg_error           <= err_next;
      clk_int_reg           <= clk_int_next;
      sel_n_reg             <= sel_n_next;
      dout_reg              <= dout_next;
      doe_reg               <= doe_next;
      first_reg             <= first_next;
      ext_prev_reg          <= i_ext_div_clk;
      sclk_prev_reg         <= s_clk;
      txact_prev_reg        <= tx_act;
      o_serial_clock_pin    <= clk_int_next ^ i_cfg.transmit_clock_polarity;
      // RULE6: master owns tx clock and frame
      o_serial_clock_pin_oe <= i_cfg.master;
      o_tx_frame_pin_oe     <= i_cfg.master;
      // RULE7: enable driven active low
      o_tx_frame_pin        <= sel_n_next;
      o_serial_out_pin      <= dout_next;
      o_serial_out_pin_oe   <= doe_next;
      o_tx_clock_direction  <= i_cfg.master ? bsp_pkg::DIR_OUT : bsp_pkg::DIR_IN;
      o_tx_frame_direction  <= i_cfg.master ? bsp_pkg::DIR_OUT : bsp_pkg::DIR_IN;
      o_rx_clock_direction  <= bsp_pkg::DIR_IN;
      o_rx_frame_direction  <= bsp_pkg::DIR_IN;
      o_tx_frame_polarity   <= bsp_pkg::FRAME_POL_INV;
      o_rx_frame_polarity   <= bsp_pkg::FRAME_POL_INV;
    end
  end

  // phase length helper, read only by assertions
  logic [8:0] ph_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) ph_reg <= 9'h000;
    else ph_reg <= (clk_int_next != clk_int_reg) ? 9'h000 : ph_reg + 9'h001;
  end

  a_slave_cfg_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE1
    (!i_cfg.master && i_cfg.divider_value != bsp_pkg::SLAVE_DIV_VALUE) |=> o_cfg_error)
    else $error("slave divider setting not flagged");
  a_ext_tick_src: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE2
    (i_cfg.divider_source_select == bsp_pkg::DIV_SRC_EXT && ext_prev_reg) |-> !tick)
    else $error("divider ticked without external edge");
  a_period_sum: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE3
    (i_cfg.divider_value != 8'h00) |-> (h_len + l_len == {1'b0, i_cfg.divider_value} + 9'h001))
    else $error("clock period differs from divide value plus one");
  a_high_phase: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE4
    (i_cfg.master && i_cfg.divider_source_select && state_reg == bsp_pkg::ST_HIGH && expire)
    |-> ph_reg == h_len - 9'h001)
    else $error("high phase length wrong");
  a_low_phase: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE5
    (i_cfg.master && i_cfg.divider_source_select && state_reg == bsp_pkg::ST_LOW && expire)
    |-> ph_reg == l_len - 9'h001)
    else $error("low phase length wrong");
  a_master_pins: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE6
    (i_cfg.master && $past(i_rst_n)) |=> (o_serial_clock_pin_oe && o_tx_frame_pin_oe && !o_rx_frame_direction))
    else $error("master pin directions wrong");
  a_enable_lead: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE9
    (i_cfg.master && $rose(clk_int_reg)) |-> !o_tx_frame_pin)
    else $error("clock rose without enable");
  a_float_early: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE13
    (i_cfg.master && !late && state_reg == bsp_pkg::ST_HIGH && expire && bit_reg == bsp_pkg::BIT_LAST)
    |=> (!o_serial_out_pin_oe && !o_tx_frame_pin))
    else $error("data not floated at last fall");
  a_slave_release: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE14
    (!i_cfg.master && i_tx_frame_pin) |=> !o_serial_out_pin_oe)
    else $error("slave kept driving after enable high");
endmodule

// ### bsp_spi_peer.sv
`timescale 1ns/1ps
module bsp_spi_peer (
  // mode and clock
  input  wire logic       i_clk,
  input  wire logic       i_half,
  // serial pins
  input  wire logic       i_sck,
  input  wire logic       i_cs_n,
  input  wire logic       i_mosi,
  output logic            o_miso,
  // words
  input  wire logic [7:0] i_word,
  output logic [7:0]      o_got
);
  logic [7:0] sh;
  int         rises;
  initial o_miso = 1'b0;
  task automatic shift;
    sh = {sh[6:0], 1'b0};
    o_miso = sh[7];
  endtask
  always @(negedge i_cs_n) begin
    sh = i_word;
    rises = 0;
    o_miso = i_word[7];
  end
  // released line has no pull, so it toggles to expose stale sampling
  always @(posedge i_clk) begin
    if (i_cs_n) o_miso = ~o_miso;
  end
  always @(posedge i_sck) begin
    if (!i_cs_n && i_half) o_got = {o_got[6:0], i_mosi};
    else if (!i_cs_n) begin
      if (rises != 0) shift();
      rises++;
    end
  end
  always @(negedge i_sck) begin
    if (!i_cs_n && i_half) shift();
    else if (!i_cs_n) o_got = {o_got[6:0], i_mosi};
  end
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [1:0] mode;
    logic       src;
    logic [7:0] div;
    logic [7:0] tx;
    logic [7:0] sw;
  } bsp_row_t;
  bsp_row_t          rows [6];
  bsp_pkg::bsp_cfg_t cfg;
  logic       i_clk = 1'b0, i_rst_n = 1'b0, tx_valid = 1'b0, tb_sck = 1'b0, tb_cs = 1'b1, tb_din = 1'b0;
  logic [1:0] ext_cnt = 2'h0;
  logic [7:0] tx_data = 8'h00, peer_word = 8'h00, got, rx_cap;
  logic       tx_ready, rx_valid, busy, cfg_err, tcd, tfd, rcd, rfd, tfp, rfp;
  logic       sck_o, sck_oe, cs_o, cs_oe, dout, dout_oe, miso, sck_q, cs_q, oe_q;
  logic [7:0] rx_data, peer_got;
  wire        sck_w = sck_oe ? sck_o : tb_sck;
  wire        cs_w  = cs_oe ? cs_o : tb_cs;
  int         cyc = 0, run, hi_w, lo_w, t_csf, t_r1, t_lf, t_oe, t_csr, rises, err_count = 0, checked = 0;

  always #2.5 i_clk = ~i_clk;

  bsp_spi_clkstop u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg(cfg), .i_ext_div_clk(ext_cnt[1]),
    .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_rx_data(rx_data),
    .o_rx_valid(rx_valid), .o_busy(busy), .o_cfg_error(cfg_err), .o_tx_clock_direction(tcd),
    .o_tx_frame_direction(tfd), .o_rx_clock_direction(rcd), .o_rx_frame_direction(rfd),
    .o_tx_frame_polarity(tfp), .o_rx_frame_polarity(rfp), .i_serial_clock_pin(sck_w),
    .o_serial_clock_pin(sck_o), .o_serial_clock_pin_oe(sck_oe), .i_tx_frame_pin(cs_w),
    .o_tx_frame_pin(cs_o), .o_tx_frame_pin_oe(cs_oe), .i_rx_frame_pin(cs_w),
    .i_serial_in_pin(cfg.master ? miso : tb_din), .o_serial_out_pin(dout), .o_serial_out_pin_oe(dout_oe));

  bsp_spi_peer u_peer (.i_clk(i_clk), .i_half(cfg.clock_stop_select == bsp_pkg::CLKSTOP_HALF_DELAY),
    .i_sck(sck_w), .i_cs_n(cs_w), .i_mosi(dout), .o_miso(miso), .i_word(peer_word), .o_got(peer_got));

  // edge monitor: widths and event times in clock cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    ext_cnt <= ext_cnt + 2'h1;
    sck_q <= sck_w;
    cs_q <= cs_w;
    oe_q <= dout_oe;
    if (rx_valid === 1'b1) rx_cap <= rx_data;
    if (sck_q !== sck_w) begin
      run <= 1;
      if (sck_q) hi_w <= run;
      else lo_w <= run;
    end else run <= run + 1;
    if (cs_q && !cs_w) begin
      t_csf <= cyc;
      rises <= 0;
    end
    if (!sck_q && sck_w) begin
      if (rises == 0) t_r1 <= cyc;
      rises <= rises + 1;
    end
    if (sck_q && !sck_w) t_lf <= cyc;
    if (oe_q && !dout_oe) t_oe <= cyc;
    if (!cs_q && cs_w) t_csr <= cyc;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic offer(input logic [7:0] d);
    tx_data <= d;
    tx_valid <= 1'b1;
    do @(posedge i_clk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic int hw(input logic [7:0] d, input bit hi);
    if (d == 8'h00) return 1;
    if (d[0]) return (int'(d) + 1) / 2;
    return hi ? int'(d) / 2 + 1 : int'(d) / 2;
  endfunction

  initial begin
    bsp_row_t r;
    int       s, h, l, k;
    logic [7:0] pat;
    cfg = '{1'b1, 2'h2, 1'b0, 1'b1, 8'h01};
    rows = '{'{2'h2, 1'b1, 8'h01, 8'ha5, 8'h3c}, '{2'h3, 1'b1, 8'h01, 8'h5a, 8'hc3},
             '{2'h2, 1'b1, 8'h04, 8'h81, 8'h7e}, '{2'h3, 1'b1, 8'h03, 8'h01, 8'h80},
             '{2'h2, 1'b1, 8'h00, 8'hff, 8'h00}, '{2'h2, 1'b0, 8'h01, 8'h96, 8'h69}};
    repeat (5) @(posedge i_clk);
    chk(16'(cs_o & tfp & rfp), 16'h0001, "reset frame");
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk(16'({tcd, tfd, rcd, rfd}), 16'h000c, "directions");
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      r = rows[i];
      s = r.src ? 1 : 4;
      h = hw(r.div, 1'b1) * s;
      l = hw(r.div, 1'b0) * s;
      cfg <= '{1'b1, r.mode, 1'b0, r.src, r.div};
      peer_word <= r.sw;
      repeat (3) @(posedge i_clk);
      offer(r.tx);
      k = 0;
      do begin
        @(posedge i_clk);
        k++;
      end while (busy !== 1'b0 && k < 2000);
      repeat (3) @(posedge i_clk);
      chk(16'(rx_cap), 16'(r.sw), "master rx");
      chk(16'(peer_got), 16'(r.tx), "master tx");
      chk(16'(hi_w), 16'(h), "high width");
      chk(16'(lo_w), 16'(l), "low width");
      // a zero divide value is stretched to one cycle per phase
      chk(16'(hi_w + lo_w), 16'((r.div == 8'h00 ? 2 : 1 + int'(r.div)) * s), "period");
      chk(16'(rises), 16'h0008, "edge count");
      if (r.src) begin
        chk(16'(t_r1 - t_csf), 16'(r.mode == bsp_pkg::CLKSTOP_NO_DELAY ? l : h + l), "lead");
        chk(16'(t_csr - t_lf), 16'(r.mode == bsp_pkg::CLKSTOP_NO_DELAY ? h + l : l), "hold");
        chk(16'(t_oe - t_lf), 16'(r.mode == bsp_pkg::CLKSTOP_NO_DELAY ? l : 0), "float");
      end
      $display("test master row %0d done", i);
    end
    cfg <= '{1'b1, 2'h0, 1'b1, 1'b1, 8'h01};
    repeat (3) @(posedge i_clk);
    chk(16'({sck_o, tx_ready}), 16'h0002, "stopped mode");
    cfg <= '{1'b0, 2'h2, 1'b0, 1'b1, 8'h02};
    repeat (3) @(posedge i_clk);
    chk(16'(cfg_err), 16'h0001, "slave bad divider");
    for (int m = 2; m < 4; m++) begin
      cfg <= '{1'b0, 2'(m), 1'b0, 1'b1, 8'h01};
      pat = (m == 2) ? 8'h4b : 8'hb4;
      repeat (3) @(posedge i_clk);
      chk(16'(cfg_err), 16'h0000, "slave divider");
      chk(16'(dout_oe), 16'h0000, "slave idle");
      offer(8'hd2);
      // enable held low for the whole word
      tb_cs <= 1'b0;
      repeat (4) @(posedge i_clk);
      for (int b = 7; b >= 0; b--) begin
        // data moves only while the clock is low, so both modes see it settled
        tb_din <= pat[b];
        repeat (2) @(posedge i_clk);
        if (m == 3) got[b] = dout;
        tb_sck <= 1'b1;
        repeat (4) @(posedge i_clk);
        if (m == 2) got[b] = dout;
        tb_sck <= 1'b0;
        repeat (2) @(posedge i_clk);
      end
      chk(16'(dout_oe), 16'h0001, "slave driving");
      tb_cs <= 1'b1;
      repeat (4) @(posedge i_clk);
      chk(16'(dout_oe), 16'h0000, "slave release");
      chk(16'(got), 16'h00d2, "slave tx");
      chk(16'(rx_cap), 16'(pat), "slave rx");
      $display("test slave mode %0d done", m);
    end
    print_verdict();
  end
endmodule
